// ---- core/aodc_pkg.sv ----
// Package for the audio output driver control block: register map, fields, timing.
// Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
`default_nettype none
package aodc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_POWER = 8'h05;
  localparam logic [7:0] IDX_VOLCTL = 8'h1d;
  localparam logic [7:0] IDX_SCCAP = 8'h20;
  localparam logic [7:0] IDX_SCCFG = 8'h21;
  localparam logic [7:0] IDX_POPCTL = 8'h25;
  localparam logic [7:0] IDX_ROUTE = 8'h2a;
  localparam logic [7:0] IDX_INTSTAT = 8'h2b;
  localparam logic [7:0] IDX_INTMASK = 8'h2c;
  // Power register fields, then the volume-control short flag and the short-circuit config fields
  localparam int P_DAC_PD = 15;
  localparam int P_HPL_PD = 12;
  localparam int P_HPR_PD = 11;
  localparam int P_DIR = 10;
  localparam int P_VIRTUAL_GROUND_AMP_PD = 8;
  localparam int P_SPK_PD = 7;
  localparam int P_RCV_PD = 6;
  localparam int P_STAT_L = 4;
  localparam int P_STAT_R = 3;
  localparam logic [15:0] POWER_WMASK = 16'h99c0;
  localparam logic [15:0] POWER_RESET = 16'h99c0;
  localparam int V_SHORT = 1;
  localparam int C_CAP_SC_DIS = 0;
  localparam int C_CAPLESS_DIS = 3;
  localparam int C_VIRTUAL_GROUND_AMP_SC_DIS = 4;
  localparam int C_SPK_SC_EN = 5;
  localparam logic [15:0] SCCFG_WMASK = 16'h0038;
  // Pop control fields; status flags sit in the top six bits
  localparam int Q_STAT_LSB = 10;
  localparam int Q_BUZ_L = 7;
  localparam int Q_BUZ_R = 6;
  localparam int Q_POP_DIS = 5;
  localparam int Q_LONG = 4;
  localparam logic [15:0] POPCTL_WMASK = 16'h00f0;
  // Route: [1:0] left hp source, [3:2] right hp source, [5:4] speaker L/R
  localparam logic [1:0] SRC_LEFT = 2'h1;
  localparam logic [1:0] SRC_RIGHT = 2'h2;
  localparam logic [1:0] SRC_MIX = 2'h3;
  localparam logic [15:0] ROUTE_WMASK = 16'h003f;
  localparam logic [15:0] ROUTE_RESET = 16'h0000;
  // Interrupt events
  localparam int EV_SHORT = 0;
  localparam int EV_DAC_UP = 1;
  localparam int EV_DAC_DOWN = 2;
  localparam int EV_POP_DONE = 3;
  localparam int EV_N = 4;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int CLK_KHZ = CLK_MHZ * 1000;
  localparam int POP_SHORT_MS = 800;
  localparam int POP_LONG_MS = 4000;
  localparam int VIRTUAL_GROUND_AMP_UP_MS = 1;
  localparam int POP_SHORT_CYC = POP_SHORT_MS * CLK_KHZ;
  localparam int POP_LONG_CYC = POP_LONG_MS * CLK_KHZ;
  localparam int VIRTUAL_GROUND_AMP_UP_CYC = VIRTUAL_GROUND_AMP_UP_MS * CLK_KHZ;
  localparam int TIMER_W = 32;
  // AHB-Lite codes
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic hpLeft;
    logic hpRight;
    logic spk;
    logic rcv;
    logic virtual_ground_amp;
  } aodc_drv_type;

  typedef struct packed {
    logic hp;
    logic virtual_ground_amp;
    logic spk;
  } aodc_short_type;

  typedef struct packed {
    logic [1:0] hpLeftSrc;
    logic [1:0] hpRightSrc;
    logic [1:0] spkSrc;
    logic [1:0] buzzerRoute;
  } aodc_route_type;
endpackage : aodc_pkg
`default_nettype wire

// ---- core/aodc_sync.sv ----
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes inputs come from pins outside the clock domain.
`timescale 1ns/1ns
`default_nettype none
module aodc_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      syncOut <= '0;
    end else if (ce) begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule : aodc_sync
`default_nettype wire

// ---- core/aodc_timer.sv ----
// Loadable down-counter; busy while counting, one-cycle done pulse at the end.
// Assumes start is a one-cycle pulse from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module aodc_timer #(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic start,
  input wire logic abort,
  input wire logic [WIDTH-1:0] cycles,
  output logic busy,
  output logic done
);
  logic [WIDTH-1:0] count_q;
  initial begin
    if (WIDTH < 2) $error("aodc_timer WIDTH too small");
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      count_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
        count_q <= '0;
      end else if (start) begin
        busy <= 1'b1;
        count_q <= (cycles == '0) ? WIDTH'(1) : cycles;
      end else if (busy) begin
        if (count_q == WIDTH'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        count_q <= count_q - WIDTH'(1);
      end
    end
  end
endmodule : aodc_timer
`default_nettype wire

// ---- core/aodc_output_ctrl.sv ----
// Audio output driver control: DAC power status, routing, short protection, pop reduction.
// Assumes an AHB-Lite master on the same clock and short detectors as async pins.
//
// Notes on behaviour
// R1 - Three-bit DAC status: direction, left, right
// R2 - Direction clear: one means still powering up
// R3 - Direction set: one means stably powered down
// R4 - Up waits programmed delay; down waits ramp
// R5 - Unrouted analog outputs stay powered down
// R6 - Either DAC channel, or both mixed, per headphone
// R7 - Software powers virtual ground for capless use
// R8 - Short disables all outputs, sets flag
// R9 - Reset or all-drivers-down clears short state
// R10 - Disable bits turn off headphone short protection
// R11 - Pop reduction on after reset, bit disables
// R12 - Cap charging 0.8 s or 4 s
// R13 - Capless virtual ground: 1 ms power-up
// R14 - Pop sequence on every headphone power-up
// R15 - Speaker short protection only when enabled
// R16 - One or both DAC channels to speaker
// R17 - Receiver and headphones never on together
// R18 - Headphone signals to speaker via buzzer stage
// R19 - Read-only status ignores software writes
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module aodc_output_ctrl #(
  parameter int DAC_UP_CYCLES = 1000,
  parameter int POP_SHORT_CYCLES = aodc_pkg::POP_SHORT_CYC,
  parameter int POP_LONG_CYCLES = aodc_pkg::POP_LONG_CYC,
  parameter int VIRTUAL_GROUND_AMP_UP_CYCLES = aodc_pkg::VIRTUAL_GROUND_AMP_UP_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] volRampDone,
  input wire aodc_pkg::aodc_short_type shortPins,
  output aodc_pkg::aodc_drv_type drvEnable,
  output aodc_pkg::aodc_route_type routeSel,
  output logic popCharging,
  output logic irq
);
  localparam int TW = aodc_pkg::TIMER_W;

  initial begin
    if (DAC_UP_CYCLES < 1 || POP_SHORT_CYCLES < 1 || POP_LONG_CYCLES < 1 || VIRTUAL_GROUND_AMP_UP_CYCLES < 1) begin
      $error("aodc_output_ctrl: counts must be at least one");
    end
  end

  typedef enum logic [3:0] {
    DAC_OFF = 4'b0001,
    DAC_RISE = 4'b0010,
    DAC_ON = 4'b0100,
    DAC_FALL = 4'b1000
  } aodc_dac_type;

  // Software registers
  logic [15:0] power_q;
  logic [15:0] sccap_q;
  logic [15:0] sccfg_q;
  logic [15:0] popctl_q;
  logic [15:0] route_q;
  logic [aodc_pkg::EV_N-1:0] intStat_q;
  logic [aodc_pkg::EV_N-1:0] intMask_q;
  // Internal state
  aodc_dac_type dac_q;
  logic [1:0] chDown_q;
  logic shortFlag_q;
  logic hpOn_q;
  aodc_pkg::aodc_short_type shortSync;
  // Bus
  logic pend_q;
  logic pendWrite_q;
  logic [7:0] pendIdx_q;

  function automatic logic [15:0] mergeBits(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [15:0] mask);
    mergeBits = (old & ~mask) | (wd[15:0] & mask);
  endfunction : mergeBits

  function automatic logic srcUsed(input logic [1:0] src);
    srcUsed = (src != 2'h0);
  endfunction : srcUsed

  // Bus address phase
  logic addrTake;
  logic wrStrobe;
  assign addrTake = hsel && hready && htrans[1];
  assign wrStrobe = pend_q && pendWrite_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      pend_q <= 1'b0;
      pendWrite_q <= 1'b0;
      pendIdx_q <= '0;
      hreadyout <= 1'b1;
      hresp <= aodc_pkg::HRESP_OKAY;
    end else if (ce) begin
      hresp <= aodc_pkg::HRESP_OKAY;
      if (pend_q) begin
        pend_q <= 1'b0;
        hreadyout <= 1'b1;
      end else if (addrTake) begin
        pend_q <= 1'b1;
        pendWrite_q <= hwrite;
        pendIdx_q <= haddr[9:2];
        hreadyout <= 1'b0;
      end
    end
  end

  // Driver requests from power-down bits and routing
  logic hpLeftReq;
  logic hpRightReq;
  logic hpReq;
  logic spkReq;
  logic rcvReq;
  logic vgndReq;
  logic capless;
  logic allDown;
  logic [5:0] drvStat;
  always_comb begin
    hpLeftReq = !power_q[aodc_pkg::P_HPL_PD] && srcUsed(route_q[1:0]); // R5 R6
    hpRightReq = !power_q[aodc_pkg::P_HPR_PD] && srcUsed(route_q[3:2]); // R5 R6
    hpReq = hpLeftReq || hpRightReq;
    spkReq = !power_q[aodc_pkg::P_SPK_PD]
      && (srcUsed(route_q[5:4]) || popctl_q[aodc_pkg::Q_BUZ_L] || popctl_q[aodc_pkg::Q_BUZ_R]); // R5 R16 R18
    rcvReq = !power_q[aodc_pkg::P_RCV_PD] && !hpReq; // R17
    vgndReq = !power_q[aodc_pkg::P_VIRTUAL_GROUND_AMP_PD];
    capless = vgndReq && !sccfg_q[aodc_pkg::C_CAPLESS_DIS];
    drvStat = ~{drvEnable.hpLeft, drvEnable.hpRight, drvEnable.spk, drvEnable.spk,
                drvEnable.rcv, drvEnable.virtual_ground_amp};
    allDown = power_q[aodc_pkg::P_HPL_PD] && power_q[aodc_pkg::P_HPR_PD]
      && power_q[aodc_pkg::P_VIRTUAL_GROUND_AMP_PD] && power_q[aodc_pkg::P_SPK_PD]
      && power_q[aodc_pkg::P_RCV_PD] && (&drvStat);
  end

  // Short detection
  logic shortHit;
  assign shortHit = (shortSync.hp && !sccap_q[aodc_pkg::C_CAP_SC_DIS]) // R10
    || (shortSync.virtual_ground_amp && capless && !sccfg_q[aodc_pkg::C_VIRTUAL_GROUND_AMP_SC_DIS]) // R10
    || (shortSync.spk && sccfg_q[aodc_pkg::C_SPK_SC_EN]); // R15

  aodc_sync #(
    .WIDTH($bits(aodc_pkg::aodc_short_type))
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .asyncIn(shortPins),
    .syncOut(shortSync)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      shortFlag_q <= 1'b0; // R9
    end else if (ce) begin
      if (shortHit) begin
        shortFlag_q <= 1'b1; // R8
      end else if (allDown) begin
        shortFlag_q <= 1'b0; // R9
      end
    end
  end

  // Pop reduction timer, restarted on each headphone power-up
  logic popStart;
  logic popDone;
  logic popBusy;
  logic [TW-1:0] popCycles;
  assign popStart = hpReq && !hpOn_q && !shortFlag_q; // R14
  always_comb begin
    if (capless) begin
      popCycles = TW'(VIRTUAL_GROUND_AMP_UP_CYCLES); // R13
    end else if (popctl_q[aodc_pkg::Q_POP_DIS]) begin
      popCycles = TW'(1); // R11
    end else if (popctl_q[aodc_pkg::Q_LONG]) begin
      popCycles = TW'(POP_LONG_CYCLES); // R12
    end else begin
      popCycles = TW'(POP_SHORT_CYCLES); // R12
    end
  end

  aodc_timer #(
    .WIDTH(TW)
  ) u_pop_timer (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .start(popStart),
    .abort(!hpReq || shortFlag_q),
    .cycles(popCycles),
    .busy(popBusy),
    .done(popDone)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      hpOn_q <= 1'b0;
    end else if (ce) begin
      hpOn_q <= hpReq && !shortFlag_q;
    end
  end

  // Driver enables and routing outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      drvEnable <= '0;
      popCharging <= 1'b0;
      routeSel <= '0;
    end else if (ce) begin
      drvEnable.hpLeft <= hpLeftReq && !shortFlag_q && !shortHit; // R8
      drvEnable.hpRight <= hpRightReq && !shortFlag_q && !shortHit; // R8
      drvEnable.spk <= spkReq && !shortFlag_q && !shortHit; // R8
      drvEnable.rcv <= rcvReq && !shortFlag_q && !shortHit; // R8 R17
      drvEnable.virtual_ground_amp <= vgndReq && !shortFlag_q && !shortHit; // R8
      popCharging <= popBusy && !capless && !popctl_q[aodc_pkg::Q_POP_DIS]; // R12
      routeSel.hpLeftSrc <= route_q[1:0]; // R6
      routeSel.hpRightSrc <= route_q[3:2]; // R6
      routeSel.spkSrc <= route_q[5:4]; // R16
      routeSel.buzzerRoute <= {popctl_q[aodc_pkg::Q_BUZ_L], popctl_q[aodc_pkg::Q_BUZ_R]}; // R18
    end
  end

  // DAC power sequencing
  logic dacUpStart;
  logic dacUpDone;
  logic dacUpBusy;
  logic dacPdReq;
  assign dacPdReq = power_q[aodc_pkg::P_DAC_PD];
  assign dacUpStart = (dac_q == DAC_OFF) && !dacPdReq;

  aodc_timer #(
    .WIDTH(TW)
  ) u_dac_timer (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .start(dacUpStart),
    .abort(dacPdReq),
    .cycles(TW'(DAC_UP_CYCLES)),
    .busy(dacUpBusy),
    .done(dacUpDone)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      dac_q <= DAC_OFF;
      chDown_q <= 2'b11;
    end else if (ce) begin
      unique case (dac_q)
        DAC_OFF: begin
          if (!dacPdReq) begin
            dac_q <= DAC_RISE;
          end
        end
        DAC_RISE: begin
          if (dacPdReq) begin
            dac_q <= DAC_FALL;
            chDown_q <= 2'b00;
          end else if (dacUpDone) begin
            dac_q <= DAC_ON; // R4
          end
        end
        DAC_ON: begin
          if (dacPdReq) begin
            dac_q <= DAC_FALL;
            chDown_q <= 2'b00;
          end
        end
        DAC_FALL: begin
          chDown_q <= chDown_q | volRampDone; // R4
          if (&(chDown_q | volRampDone)) begin
            dac_q <= DAC_OFF;
          end
        end
      endcase
    end
  end

  // Status bits for the power register
  logic dirBit;
  logic [1:0] chStat;
  always_comb begin
    dirBit = (dac_q == DAC_FALL) || (dac_q == DAC_OFF); // R1
    if (dirBit) begin
      chStat = (dac_q == DAC_OFF) ? 2'b11 : chDown_q; // R3
    end else begin
      chStat = (dac_q == DAC_RISE || dacUpBusy) ? 2'b11 : 2'b00; // R2
    end
  end

  // Interrupt events
  logic [aodc_pkg::EV_N-1:0] events;
  logic shortFlagPrev_q;
  logic dacFallPrev_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      shortFlagPrev_q <= 1'b0;
      dacFallPrev_q <= 1'b0;
    end else if (ce) begin
      shortFlagPrev_q <= shortFlag_q;
      dacFallPrev_q <= (dac_q == DAC_FALL);
    end
  end
  always_comb begin
    events = '0;
    events[aodc_pkg::EV_SHORT] = shortFlag_q && !shortFlagPrev_q;
    events[aodc_pkg::EV_DAC_UP] = dacUpDone && !dacPdReq;
    events[aodc_pkg::EV_DAC_DOWN] = dacFallPrev_q && (dac_q == DAC_OFF);
    events[aodc_pkg::EV_POP_DONE] = popDone;
  end

  // Register writes; read-only fields are masked out
  always_ff @(posedge clk) begin
    if (reset) begin
      power_q <= aodc_pkg::POWER_RESET;
      sccap_q <= '0;
      sccfg_q <= '0;
      popctl_q <= '0; // R11
      route_q <= aodc_pkg::ROUTE_RESET;
      intMask_q <= '0;
    end else if (ce && wrStrobe) begin
      unique case (pendIdx_q)
        aodc_pkg::IDX_POWER: power_q <= mergeBits(power_q, hwdata, aodc_pkg::POWER_WMASK); // R19
        aodc_pkg::IDX_SCCAP: sccap_q[aodc_pkg::C_CAP_SC_DIS] <= hwdata[aodc_pkg::C_CAP_SC_DIS]; // R10
        aodc_pkg::IDX_SCCFG: sccfg_q <= mergeBits(sccfg_q, hwdata, aodc_pkg::SCCFG_WMASK);
        aodc_pkg::IDX_POPCTL: popctl_q <= mergeBits(popctl_q, hwdata, aodc_pkg::POPCTL_WMASK); // R11 R19
        aodc_pkg::IDX_ROUTE: route_q <= mergeBits(route_q, hwdata, aodc_pkg::ROUTE_WMASK);
        aodc_pkg::IDX_INTMASK: intMask_q <= hwdata[aodc_pkg::EV_N-1:0];
        default: ;
      endcase
    end
  end

  // Sticky status: a new event wins over a write-one clear
  always_ff @(posedge clk) begin
    if (reset) begin
      intStat_q <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      if (wrStrobe && pendIdx_q == aodc_pkg::IDX_INTSTAT) begin
        intStat_q <= (intStat_q & ~hwdata[aodc_pkg::EV_N-1:0]) | events;
      end else begin
        intStat_q <= intStat_q | events;
      end
      irq <= |(intStat_q & intMask_q);
    end
  end

  // Read data, loaded in the first data-phase cycle so earlier writes are seen
  logic [15:0] rdWord;
  always_comb begin
    rdWord = '0;
    unique case (pendIdx_q)
      aodc_pkg::IDX_POWER: begin
        rdWord = power_q & aodc_pkg::POWER_WMASK;
        rdWord[aodc_pkg::P_DIR] = dirBit; // R1
        rdWord[aodc_pkg::P_STAT_L] = chStat[1]; // R1
        rdWord[aodc_pkg::P_STAT_R] = chStat[0]; // R1
      end
      aodc_pkg::IDX_VOLCTL: rdWord[aodc_pkg::V_SHORT] = shortFlag_q; // R8
      aodc_pkg::IDX_SCCAP: rdWord = sccap_q;
      aodc_pkg::IDX_SCCFG: rdWord = sccfg_q;
      aodc_pkg::IDX_POPCTL: begin
        rdWord = popctl_q;
        rdWord[aodc_pkg::Q_STAT_LSB +: 6] = drvStat; // R9
      end
      aodc_pkg::IDX_ROUTE: rdWord = route_q;
      aodc_pkg::IDX_INTSTAT: rdWord[aodc_pkg::EV_N-1:0] = intStat_q;
      aodc_pkg::IDX_INTMASK: rdWord[aodc_pkg::EV_N-1:0] = intMask_q;
      default: rdWord = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hrdata <= '0;
    end else if (ce && pend_q && !pendWrite_q) begin
      hrdata <= {16'h0000, rdWord};
    end
  end
endmodule : aodc_output_ctrl
`default_nettype wire

// ---- sim/aodc_output_ctrl_chk.sv ----
// Port-level checker for the audio output driver control block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module aodc_output_ctrl_chk #(
  parameter int POP_LONG_CYCLES = 400000000
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire aodc_pkg::aodc_drv_type drvEnable,
  input wire aodc_pkg::aodc_route_type routeSel,
  input wire logic popCharging,
  input wire logic irq
);
  int popCnt;
  logic hpAny;
  assign hpAny = drvEnable.hpLeft | drvEnable.hpRight;
  // A charging run that never ends would hold the headphone muted
  always_ff @(posedge clk) begin
    if (reset || !popCharging) popCnt <= 0;
    else popCnt <= popCnt + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_rcv_hp_excl: assert property (!(drvEnable.rcv && hpAny))
    else $error("receiver and headphone on together");
  a_hpl_unrouted: assert property ((routeSel.hpLeftSrc == 2'h0) [*2] |-> !drvEnable.hpLeft)
    else $error("unrouted left headphone powered");
  a_hpr_unrouted: assert property ((routeSel.hpRightSrc == 2'h0) [*2] |-> !drvEnable.hpRight)
    else $error("unrouted right headphone powered");
  a_pop_needs_hp: assert property ($rose(popCharging) |-> hpAny)
    else $error("charging without a headphone driver");
  a_pop_on_rise: assert property ($rose(popCharging) |-> $past(hpAny) && !$past(hpAny, 2))
    else $error("charging not started by a headphone power-up");
  a_pop_bounded: assert property (popCnt <= POP_LONG_CYCLES + 2)
    else $error("charging run too long");
  a_bus_one_wait: assert property ((hsel && hready && htrans[1]) |=> !hreadyout ##1 hreadyout)
    else $error("wait state not exactly one cycle");
  a_resp_okay: assert property (hresp == aodc_pkg::HRESP_OKAY)
    else $error("error response");
  a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0)
    reset |=> !irq && drvEnable == '0 && !popCharging)
    else $error("outputs active after reset");
  c_pop: cover property ($rose(popCharging));
  c_irq: cover property ($rose(irq));
  c_spk: cover property (drvEnable.spk);
  c_mix: cover property (routeSel.hpLeftSrc == aodc_pkg::SRC_MIX);
endmodule : aodc_output_ctrl_chk
bind aodc_output_ctrl aodc_output_ctrl_chk #(.POP_LONG_CYCLES(POP_LONG_CYCLES)) u_aodc_output_ctrl_chk (
  .clk(clk), .reset(reset), .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .drvEnable(drvEnable), .routeSel(routeSel), .popCharging(popCharging), .irq(irq));
`default_nettype wire

// ---- sim/aodc_load_model.sv ----
// Analog loads: short detectors and volume ramp completion.
// Assumes the bench commands shorts and ramps on the system clock.
`timescale 1ns/1ns
`default_nettype none
module aodc_load_model #(
  parameter int RAMP = 4
) (
  input wire logic clk,
  input wire aodc_pkg::aodc_drv_type drvEnable,
  input wire aodc_pkg::aodc_short_type shortCmd,
  input wire logic [1:0] rampGo,
  output aodc_pkg::aodc_short_type shortPins,
  output logic [1:0] volRampDone
);
  int cntL = 0;
  int cntR = 0;
  // A load shows a short only while its driver pushes current into it
  assign shortPins.hp = shortCmd.hp & (drvEnable.hpLeft | drvEnable.hpRight);
  assign shortPins.virtual_ground_amp = shortCmd.virtual_ground_amp & drvEnable.virtual_ground_amp;
  assign shortPins.spk = shortCmd.spk & drvEnable.spk;
  assign volRampDone = rampGo & {cntL == RAMP, cntR == RAMP};
  always @(posedge clk) begin
    cntL <= rampGo[1] ? ((cntL < RAMP) ? cntL + 1 : RAMP) : 0;
    cntR <= rampGo[0] ? ((cntR < RAMP) ? cntR + 1 : RAMP) : 0;
  end
endmodule : aodc_load_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench: AHB-Lite register tasks driving the output control block.
// Assumes shortened timing parameters and the load model on the analog side.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED t=%0t %s", $time, m); end end
module tb_top;
  localparam int PP_LEN [4] = '{20, 40, 10, 1};
  localparam logic [31:0] PP_CTL [4] = '{32'h0, 32'h10, 32'h0, 32'h20};
  localparam logic [31:0] PP_PWR [4] = '{32'h8180, 32'h8180, 32'h8080, 32'h8180};
  // Capless and disabled runs never charge the coupling capacitors
  localparam int PP_MIN [4] = '{18, 35, 0, 0};
  localparam int PP_MAX [4] = '{22, 42, 0, 0};
  localparam logic [31:0] SC_CAP [5] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0};
  localparam logic [31:0] SC_CFG [5] = '{32'h0, 32'h0, 32'h0, 32'h20, 32'h10};
  localparam logic [31:0] SC_PWR [5] = '{32'h81c0, 32'h81c0, 32'h9940, 32'h9940, 32'h80c0};
  localparam aodc_pkg::aodc_short_type SC_SHORT [5] = '{3'b100, 3'b100, 3'b001, 3'b001, 3'b010};
  localparam logic SC_FLAG [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic hready;
  logic [1:0] volRampDone;
  logic [1:0] rampGo = 2'b00;
  aodc_pkg::aodc_short_type shortPins;
  aodc_pkg::aodc_short_type shortCmd = '0;
  aodc_pkg::aodc_drv_type drvEnable;
  aodc_pkg::aodc_route_type routeSel;
  logic popCharging;
  logic irq;
  logic [31:0] rd;
  int err_total = 0;
  int check_count = 0;
  int popRun = 0;
  int popLast = 0;
  assign hready = hreadyout;
  always #5 clk = ~clk;
  aodc_output_ctrl #(.DAC_UP_CYCLES(40), .POP_SHORT_CYCLES(20), .POP_LONG_CYCLES(40), .VIRTUAL_GROUND_AMP_UP_CYCLES(10))
  u_aodc_output_ctrl (.clk(clk), .reset(reset), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .volRampDone(volRampDone), .shortPins(shortPins), .drvEnable(drvEnable),
    .routeSel(routeSel), .popCharging(popCharging), .irq(irq));
  aodc_load_model u_aodc_load_model (.clk(clk), .drvEnable(drvEnable), .shortCmd(shortCmd), .rampGo(rampGo),
    .shortPins(shortPins), .volRampDone(volRampDone));
  // Length of the last finished charging run
  always @(posedge clk) begin
    if (popCharging) popRun <= popRun + 1;
    else begin
      if (popRun != 0) popLast <= popRun;
      popRun <= 0;
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk
  // Called just after a rising edge; holds each phase until hready is sampled high
  task automatic bus_xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wdata);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= aodc_pkg::HSIZE_WORD;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= aodc_pkg::HTRANS_IDLE;
    hwdata <= wdata;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
    rd = hrdata;
    `CHK(n < 50 && hresp === aodc_pkg::HRESP_OKAY, 1'b1, "bus transfer")
  endtask : bus_xfer
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus_xfer(idx, 1'b1, d);
  endtask : wr
  task automatic rdv(input logic [7:0] idx, input logic [31:0] e, input string m);
    bus_xfer(idx, 1'b0, 32'h0);
    `CHK(rd, e, m)
  endtask : rdv
  task automatic dac_stat(input logic [2:0] e);
    bus_xfer(aodc_pkg::IDX_POWER, 1'b0, 32'h0);
    `CHK({rd[aodc_pkg::P_DIR], rd[aodc_pkg::P_STAT_L], rd[aodc_pkg::P_STAT_R]}, e, "dac status")
  endtask : dac_stat
  initial begin
    wait_clk(20000);
    err_total++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    wait_clk(5);
    reset <= 1'b0;
    @(posedge clk);
    `CHK({drvEnable, routeSel, irq, popCharging}, 15'h0, "outputs after reset")
    bus_xfer(aodc_pkg::IDX_POWER, 1'b0, 32'h0);
    `CHK(rd & 32'h99c0, 32'h99c0, "power reset value")
    rdv(aodc_pkg::IDX_POPCTL, 32'hfc00, "pop control reset value");
    rdv(aodc_pkg::IDX_SCCFG, 32'h0, "short config reset value");
    wr(8'hf0, 32'hffff);
    rdv(8'hf0, 32'h0, "unmapped read");
    $display("test reset done");
    wr(aodc_pkg::IDX_POWER, 32'h19c0);
    dac_stat(3'b011);
    wait_clk(50);
    dac_stat(3'b000);
    rdv(aodc_pkg::IDX_INTSTAT, 32'h2, "dac up event");
    `CHK(irq, 1'b0, "masked event")
    wr(aodc_pkg::IDX_POWER, 32'h99c0);
    dac_stat(3'b100);
    rampGo <= 2'b10;
    wait_clk(10);
    dac_stat(3'b110);
    rampGo <= 2'b11;
    wait_clk(10);
    dac_stat(3'b111);
    rampGo <= 2'b00;
    wr(aodc_pkg::IDX_INTSTAT, 32'hf);
    $display("test dac power done");
    for (int i = 0; i < 4; i++) begin
      wr(aodc_pkg::IDX_ROUTE, 32'h15 * i);
      wait_clk(2);
      `CHK({routeSel.hpLeftSrc, routeSel.hpRightSrc, routeSel.spkSrc}, {3{i[1:0]}}, "route")
    end
    $display("test routing done");
    wr(aodc_pkg::IDX_ROUTE, 32'h9);
    for (int i = 0; i < 4; i++) begin
      wr(aodc_pkg::IDX_POPCTL, PP_CTL[i]);
      wr(aodc_pkg::IDX_POWER, 32'h99c0);
      wait_clk(5);
      popLast = 0;
      wr(aodc_pkg::IDX_INTSTAT, 32'h8);
      wr(aodc_pkg::IDX_POWER, PP_PWR[i]);
      if (i < 3) rdv(aodc_pkg::IDX_INTSTAT, 32'h0, "pop running");
      wait_clk(PP_LEN[i] + 10);
      rdv(aodc_pkg::IDX_INTSTAT, 32'h8, "pop done");
      `CHK(popLast >= PP_MIN[i] && popLast <= PP_MAX[i], 1'b1, "pop length")
      `CHK({drvEnable.hpLeft, drvEnable.rcv}, 2'b10, "receiver held off")
    end
    wr(aodc_pkg::IDX_POWER, 32'h99c0);
    wr(aodc_pkg::IDX_ROUTE, 32'h0);
    wr(aodc_pkg::IDX_POWER, 32'h81c0);
    wait_clk(3);
    `CHK(drvEnable.hpLeft | drvEnable.hpRight, 1'b0, "unrouted headphone")
    wr(aodc_pkg::IDX_POPCTL, 32'hc0);
    wait_clk(2);
    `CHK(routeSel.buzzerRoute, 2'b11, "buzzer route")
    rdv(aodc_pkg::IDX_POPCTL, 32'hfcc0, "buzzer route readback");
    wr(aodc_pkg::IDX_POPCTL, 32'h0);
    $display("test pop reduction done");
    wr(aodc_pkg::IDX_INTSTAT, 32'hf);
    wr(aodc_pkg::IDX_INTMASK, 32'h1);
    wr(aodc_pkg::IDX_ROUTE, 32'h15);
    for (int i = 0; i < 5; i++) begin
      wr(aodc_pkg::IDX_SCCAP, SC_CAP[i]);
      wr(aodc_pkg::IDX_SCCFG, SC_CFG[i]);
      wr(aodc_pkg::IDX_POWER, SC_PWR[i]);
      wait_clk(5);
      shortCmd <= SC_SHORT[i];
      wait_clk(10);
      `CHK(irq, SC_FLAG[i], "short interrupt")
      if (SC_FLAG[i]) `CHK(drvEnable, 5'h0, "drivers after short")
      shortCmd <= '0;
      wr(aodc_pkg::IDX_VOLCTL, 32'h0);
      rdv(aodc_pkg::IDX_VOLCTL, {30'h0, SC_FLAG[i], 1'b0}, "short flag");
      wr(aodc_pkg::IDX_POWER, 32'h99c0);
      wait_clk(10);
      rdv(aodc_pkg::IDX_POPCTL, 32'hfc00, "drivers down");
      rdv(aodc_pkg::IDX_VOLCTL, 32'h0, "short flag cleared");
      wr(aodc_pkg::IDX_INTSTAT, 32'hf);
      wait_clk(2);
      `CHK(irq, 1'b0, "interrupt cleared")
    end
    $display("test short protection done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
